// [crt_pkg.sv]
// Purpose: shared constants, tables and helpers of the coherency timing block
// Assumes: divisor codes 0..4 stand for cache clock divisors 1,1.5,2,2.5,3
// Notes: latency figures are processor clock cycles
package crt_pkg;
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] LAT_OFS = 8'h08;
    localparam logic [7:0] CNT_OFS = 8'h0c;
    localparam int CTRL_SCDIV_LSB = 0;
    localparam int CTRL_SYSDIV_LSB = 3;
    localparam int CTRL_MASTER_BIT = 5;
    localparam int STAT_OVF_BIT = 5;
    localparam logic [5:0] CTRL_RST = 6'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [2:0] Q_DEPTH = 3'h4;
    localparam logic [7:0] ST_MIN = 8'h05;
    localparam logic [7:0] DT_MIN = 8'h08;
    localparam logic [4:0][7:0] ST_TYP = {8'h11, 8'h10, 8'h0e, 8'h0d, 8'h0a};
    localparam logic [4:0][7:0] ST_MAX = {8'h4f, 8'h47, 8'h3b, 8'h30, 8'h27};
    localparam logic [4:0][7:0] DT_TYP = {8'h2b, 8'h2b, 8'h26, 8'h21, 8'h1c};
    localparam logic [4:0][7:0] DT_MAX = {8'h8d, 8'h80, 8'h69, 8'h58, 8'h46};
    localparam logic [7:0] ST_LAT_LO = 8'h06;
    localparam logic [7:0] ST_LAT_HI = 8'h52;

    typedef enum logic {CRT_IDLE, CRT_RUN} crt_fsm_e;

    // codes above 4 fold onto the slowest divisor
    function automatic logic [2:0] div_idx(input logic [2:0] d);
        div_idx = (d > 3'h4) ? 3'h4 : d;
    endfunction

    function automatic logic [7:0] miss_extra(input logic [2:0] d);
        miss_extra = (div_idx(d) < 3'h2) ? 8'h01 : (div_idx(d) < 3'h4) ? 8'h02 : 8'h03;
    endfunction

    function automatic logic [7:0] sync_extra(input logic [1:0] d);
        sync_extra = (d == 2'h0) ? 8'h01 : (d == 2'h1) ? 8'h02 : 8'h03;
    endfunction
endpackage

// [crt_ifs.sv]
// Purpose: carriers between the core, the link sampler and the latency table
// Assumes: all signals on clk
// Notes: class bits [0] buffer hit, [1] outgoing hit, [2] mru miss, [3] conflict, [4] dirty
`timescale 1ns/1ps
interface crt_link_if;
    logic link_rise;
    logic req_pulse;
    logic [1:0] req_state;
    logic [4:0] req_cls;
    logic gp_ok;
    modport smp (output link_rise, req_pulse, req_state, req_cls, gp_ok);
    modport core (input link_rise, req_pulse, req_state, req_cls, gp_ok);
endinterface

interface crt_lat_if;
    logic [2:0] scdiv;
    logic [1:0] sysdiv;
    logic [4:0] cls;
    logic [7:0] st_lat;
    logic [7:0] dt_lat;
    modport calc (input scdiv, sysdiv, cls, output st_lat, dt_lat);
    modport core (output scdiv, sysdiv, cls, input st_lat, dt_lat);
endinterface

// [crt_link_sampler.sv]
// Purpose: bring link pins into clk, find link clock rising edges
// Assumes: link clock much slower than clk
// Notes: request pins are only looked at on a link clock rising edge
`timescale 1ns/1ps
module crt_link_sampler
    import crt_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic system_interface_clock,
    input wire logic global_perform_ack_n,
    input wire logic coh_req_valid,
    input wire logic [1:0] coh_req_state,
    input wire logic [4:0] coh_req_class,
    crt_link_if.smp lk
);
    typedef struct packed {
        logic [9:0] s1;
        logic [9:0] s2;
        logic sic_d;
        logic rise;
        logic req;
        logic [1:0] st;
        logic [4:0] cls;
        logic gp_ok;
    } crt_smp_s;

    crt_smp_s s_ff;
    crt_smp_s nxt_s;
    logic edge_now;

    assign edge_now = s_ff.s2[9] && !s_ff.sic_d;

    always_comb
    begin
        nxt_s = s_ff;
        nxt_s.s1 = {system_interface_clock, global_perform_ack_n, coh_req_valid, coh_req_state, coh_req_class};
        nxt_s.s2 = s_ff.s1;
        nxt_s.sic_d = s_ff.s2[9];
        nxt_s.rise = edge_now;
        nxt_s.req = edge_now && s_ff.s2[7];
        if (edge_now)
        begin
            nxt_s.st = s_ff.s2[6:5];
            nxt_s.cls = s_ff.s2[4:0];
            nxt_s.gp_ok = !s_ff.s2[8];
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            s_ff <= '0;
        else
            s_ff <= nxt_s;
    end

    assign lk.link_rise = s_ff.rise;
    assign lk.req_pulse = s_ff.req;
    assign lk.req_state = s_ff.st;
    assign lk.req_cls = s_ff.cls;
    assign lk.gp_ok = s_ff.gp_ok;

    property p_gp_on_edge;
        @(posedge clk) disable iff (sys_rst) !$stable(s_ff.gp_ok) |-> s_ff.rise && $past(!s_ff.s2[8]) == s_ff.gp_ok;
    endproperty
    a_gp_on_edge: assert property (p_gp_on_edge) else $error("perform flag moved off a link edge");
endmodule

// [crt_lat_calc.sv]
// Purpose: state and data response latency of the request at queue head
// Assumes: a buffer hit wins over a conflict
// Notes: purely combinational
`timescale 1ns/1ps
module crt_lat_calc
    import crt_pkg::*;
(
    crt_lat_if.calc lt
);
    logic [2:0] i;
    logic [7:0] sx;
    logic [7:0] mx;

    assign i = div_idx(lt.scdiv);
    assign sx = sync_extra(lt.sysdiv);
    assign mx = lt.cls[2] ? miss_extra(lt.scdiv) : 8'h00;

    always_comb
    begin
        if (lt.cls[0])
            lt.st_lat = ST_MIN + sx;
        else if (lt.cls[3])
            lt.st_lat = ST_MAX[i] + sx;
        else
            lt.st_lat = ST_TYP[i] + mx + sx;
        if (lt.cls[1])
            lt.dt_lat = DT_MIN + sx;
        else if (lt.cls[3])
            lt.dt_lat = DT_MAX[i] + sx;
        else
            lt.dt_lat = DT_TYP[i] + mx + sx;
    end
endmodule

// [crt_core.sv]
// Purpose: coherency response timing and barrier graduation gate
// Assumes: AXI4-Lite register access, prot signals not used
// Notes: one coherency request in flight, later ones queue in arrival order
// Contract
// - every targeting coherency request gets a state response, latency counted from the request; the code drops one arriving on a full 4-entry queue.
// - data latency ends at data response as master, at state bus bit 0 as slave.
// - state latency is at least 5 cycles, worst 39 to 79 with cache divisor.
// - with 32-word blocks data latency is at least 8, worst 141 cycles.
// - buffer hit on cached or outgoing entry gives minimum state latency.
// - outgoing buffer hit gives minimum data latency, block taken from buffer.
// - missing the most recent cache way adds 1 to 3 cycles by cache divisor.
// - link clock synchronisation adds 1 to 3 cycles by system divisor.
// - earlier outstanding requests are served first and delay later ones.
// - barrier graduates only while the perform input is asserted.
`timescale 1ns/1ps
module crt_core
    import crt_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic system_interface_clock,
    input wire logic global_perform_ack_n,
    input wire logic coh_req_valid,
    input wire logic [1:0] coh_req_state,
    input wire logic [4:0] coh_req_class,
    input wire logic sync_req,
    output logic sync_grant,
    output logic coh_state_valid,
    output logic [2:0] coherency_state_response_bus,
    output logic coh_data_resp,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp
);
    typedef struct packed {
        crt_fsm_e fsm;
        logic [5:0] ctrl;
        logic [1:0] qwp;
        logic [1:0] qrp;
        logic [2:0] qn;
        logic [3:0][6:0] q;
        logic [6:0] cur;
        logic [7:0] cnt;
        logic [7:0] stl;
        logic [7:0] dtl;
        logic st_done;
        logic dt_done;
        logic stv;
        logic [2:0] sbus;
        logic dresp;
        logic sgrant;
        logic [15:0] nresp;
        logic ovf;
        logic awh;
        logic [7:0] awa;
        logic wh;
        logic [31:0] wd;
        logic [3:0] ws;
        logic awr;
        logic wr;
        logic bv;
        logic [1:0] br;
        logic arr;
        logic rv;
        logic [31:0] rd;
        logic [1:0] rr;
    } crt_core_s;

    crt_core_s s_ff;
    crt_core_s nxt_s;
    logic pop;
    logic push_ok;

    crt_link_if lk ();
    crt_lat_if lt ();

    crt_link_sampler u_smp (
        .clk(clk),
        .sys_rst(sys_rst),
        .system_interface_clock(system_interface_clock),
        .global_perform_ack_n(global_perform_ack_n),
        .coh_req_valid(coh_req_valid),
        .coh_req_state(coh_req_state),
        .coh_req_class(coh_req_class),
        .lk(lk.smp)
    );

    crt_lat_calc u_lat (
        .lt(lt.calc)
    );

    assign lt.scdiv = s_ff.ctrl[CTRL_SCDIV_LSB +: 3];
    assign lt.sysdiv = s_ff.ctrl[CTRL_SYSDIV_LSB +: 2];
    assign lt.cls = s_ff.q[s_ff.qrp][4:0];

    // a request arriving on a full queue is dropped and flagged, never overwrites
    assign push_ok = lk.req_pulse && (s_ff.qn != Q_DEPTH);
    assign pop = (s_ff.fsm == CRT_IDLE) && (s_ff.qn != 3'h0);

    always_comb
    begin
        nxt_s = s_ff;
        nxt_s.stv = 1'b0;
        nxt_s.dresp = 1'b0;
        nxt_s.sbus[0] = 1'b0;
        // the barrier waits for the sampled perform level, not the raw pin
        nxt_s.sgrant = sync_req && lk.gp_ok;

        if (s_axi_awvalid && s_ff.awr)
        begin
            nxt_s.awh = 1'b1;
            nxt_s.awa = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_ff.wr)
        begin
            nxt_s.wh = 1'b1;
            nxt_s.wd = s_axi_wdata;
            nxt_s.ws = s_axi_wstrb;
        end
        if (s_ff.bv && s_axi_bready)
            nxt_s.bv = 1'b0;
        if (nxt_s.awh && nxt_s.wh && !nxt_s.bv)
        begin
            nxt_s.awh = 1'b0;
            nxt_s.wh = 1'b0;
            nxt_s.bv = 1'b1;
            nxt_s.br = RESP_OKAY;
            case (nxt_s.awa)
                CTRL_OFS:
                begin
                    if (nxt_s.ws[0])
                        nxt_s.ctrl = nxt_s.wd[5:0];
                end
                STAT_OFS:
                begin
                    if (nxt_s.ws[0] && nxt_s.wd[STAT_OVF_BIT])
                        nxt_s.ovf = 1'b0;
                end
                LAT_OFS, CNT_OFS:
                begin
                    nxt_s.br = RESP_OKAY;
                end
                default:
                begin
                    nxt_s.br = RESP_SLVERR;
                end
            endcase
        end
        nxt_s.awr = !nxt_s.awh && !nxt_s.bv;
        nxt_s.wr = !nxt_s.wh && !nxt_s.bv;

        if (s_ff.rv && s_axi_rready)
            nxt_s.rv = 1'b0;
        if (s_axi_arvalid && s_ff.arr)
        begin
            nxt_s.rv = 1'b1;
            nxt_s.rr = RESP_OKAY;
            case (s_axi_araddr)
                CTRL_OFS:
                    nxt_s.rd = {26'h0, s_ff.ctrl};
                STAT_OFS:
                    nxt_s.rd = {26'h0, s_ff.ovf, s_ff.qn, s_ff.fsm == CRT_RUN, lk.gp_ok};
                LAT_OFS:
                    nxt_s.rd = {16'h0, s_ff.dtl, s_ff.stl};
                CNT_OFS:
                    nxt_s.rd = {16'h0, s_ff.nresp};
                default:
                begin
                    nxt_s.rd = 32'h0;
                    nxt_s.rr = RESP_SLVERR;
                end
            endcase
        end
        nxt_s.arr = !nxt_s.rv;

        // a set from the link outranks a software clear in the same cycle
        if (lk.req_pulse && !push_ok)
            nxt_s.ovf = 1'b1;
        if (push_ok)
        begin
            nxt_s.q[s_ff.qwp] = {lk.req_state, lk.req_cls};
            nxt_s.qwp = s_ff.qwp + 2'h1;
        end
        nxt_s.qn = s_ff.qn + {2'h0, push_ok} - {2'h0, pop};

        unique case (s_ff.fsm)
            CRT_IDLE:
            begin
                if (pop)
                begin
                    nxt_s.qrp = s_ff.qrp + 2'h1;
                    nxt_s.cur = s_ff.q[s_ff.qrp];
                    nxt_s.stl = lt.st_lat;
                    nxt_s.dtl = lt.dt_lat;
                    nxt_s.cnt = 8'h00;
                    nxt_s.st_done = 1'b0;
                    nxt_s.dt_done = !lt.cls[4];
                    nxt_s.sbus = 3'h0;
                    nxt_s.fsm = CRT_RUN;
                end
            end
            CRT_RUN:
            begin
                nxt_s.cnt = s_ff.cnt + 8'h01;
                if (!s_ff.st_done && nxt_s.cnt == s_ff.stl)
                begin
                    nxt_s.stv = 1'b1;
                    nxt_s.sbus[2:1] = s_ff.cur[6:5];
                    nxt_s.st_done = 1'b1;
                    nxt_s.nresp = s_ff.nresp + 16'h0001;
                end
                if (!s_ff.dt_done && nxt_s.cnt == s_ff.dtl)
                begin
                    nxt_s.dt_done = 1'b1;
                    if (s_ff.ctrl[CTRL_MASTER_BIT])
                        nxt_s.dresp = 1'b1;
                    else
                        nxt_s.sbus[0] = 1'b1;
                end
                if (nxt_s.st_done && nxt_s.dt_done)
                    nxt_s.fsm = CRT_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            s_ff <= '0;
        else
            s_ff <= nxt_s;
    end

    assign sync_grant = s_ff.sgrant;
    assign coh_state_valid = s_ff.stv;
    assign coherency_state_response_bus = s_ff.sbus;
    assign coh_data_resp = s_ff.dresp;
    assign s_axi_awready = s_ff.awr;
    assign s_axi_wready = s_ff.wr;
    assign s_axi_bvalid = s_ff.bv;
    assign s_axi_bresp = s_ff.br;
    assign s_axi_arready = s_ff.arr;
    assign s_axi_rvalid = s_ff.rv;
    assign s_axi_rdata = s_ff.rd;
    assign s_axi_rresp = s_ff.rr;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    property p_state_resp;
        pop |-> ##[7:83] s_ff.stv;
    endproperty
    a_state_resp: assert property (p_state_resp) else $error("no state response in time");

    property p_slave_data;
        pop && lt.cls[4] && !s_ff.ctrl[CTRL_MASTER_BIT] |-> ##[10:145] s_ff.sbus[0];
    endproperty
    a_slave_data: assert property (p_slave_data) else $error("slave data indication missing");

    property p_state_bounds;
        pop |-> lt.st_lat >= ST_LAT_LO && lt.st_lat <= ST_LAT_HI;
    endproperty
    a_state_bounds: assert property (p_state_bounds) else $error("state latency out of range");

    property p_master_data;
        s_ff.dresp |-> s_ff.cnt == s_ff.dtl && s_ff.dtl >= DT_MIN + 8'h01 && s_ff.ctrl[CTRL_MASTER_BIT];
    endproperty
    a_master_data: assert property (p_master_data) else $error("data response at wrong time");

    property p_min_state;
        pop && lt.cls[0] |-> lt.st_lat == ST_MIN + sync_extra(lt.sysdiv);
    endproperty
    a_min_state: assert property (p_min_state) else $error("buffer hit not at minimum");

    property p_min_data;
        pop && lt.cls[1] |-> lt.dt_lat == DT_MIN + sync_extra(lt.sysdiv);
    endproperty
    a_min_data: assert property (p_min_data) else $error("outgoing hit not at minimum");

    property p_mru_miss;
        pop && lt.cls[3:0] == 4'h4 |-> lt.st_lat == ST_TYP[div_idx(lt.scdiv)] + miss_extra(lt.scdiv)
            + sync_extra(lt.sysdiv);
    endproperty
    a_mru_miss: assert property (p_mru_miss) else $error("way miss penalty wrong");

    property p_sync_add;
        s_ff.stv |-> s_ff.cnt == s_ff.stl && s_ff.stl > ST_MIN;
    endproperty
    a_sync_add: assert property (p_sync_add) else $error("state response off its count");

    property p_fifo;
        push_ok && !pop |=> s_ff.qn == $past(s_ff.qn) + 3'h1;
    endproperty
    a_fifo: assert property (p_fifo) else $error("queue count did not grow");

    property p_gate;
        s_ff.sgrant |-> $past(lk.gp_ok) && $past(sync_req);
    endproperty
    a_gate: assert property (p_gate) else $error("barrier graduated without perform");

    property p_bresp_hold;
        s_ff.bv && !s_axi_bready |=> s_ff.bv && $stable(s_ff.br);
    endproperty
    a_bresp_hold: assert property (p_bresp_hold) else $error("write response dropped");

    property p_rdata_hold;
        s_ff.rv && !s_axi_rready |=> s_ff.rv && $stable(s_ff.rd) && $stable(s_ff.rr);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved before taken");

    property p_grant_on;
        sync_req && lk.gp_ok |=> s_ff.sgrant;
    endproperty
    a_grant_on: assert property (p_grant_on) else $error("barrier held although performed");

    property p_drop_flag;
        lk.req_pulse && s_ff.qn == Q_DEPTH |=> s_ff.ovf;
    endproperty
    a_drop_flag: assert property (p_drop_flag) else $error("dropped request not flagged");

    property p_state_code;
        s_ff.stv |-> s_ff.sbus[2:1] == s_ff.cur[6:5];
    endproperty
    a_state_code: assert property (p_state_code) else $error("state code differs from request");
endmodule

// [crt_agent_model.sv]
// Purpose: external agent model on the link side
// Assumes: link clock runs free, unrelated in phase to clk
// Notes: request lines change at falling link edges, clear of the sampling edge
`timescale 1ns/1ps
module crt_agent_model (
    output logic system_interface_clock,
    output logic global_perform_ack_n,
    output logic coh_req_valid,
    output logic [1:0] coh_req_state,
    output logic [4:0] coh_req_class
);
    initial
    begin
        system_interface_clock = 1'b0;
        global_perform_ack_n = 1'b0;
        coh_req_valid = 1'b0;
        coh_req_state = 2'h0;
        coh_req_class = 5'h00;
        #1.3;
        forever #62.5 system_interface_clock = ~system_interface_clock;
    end
    // one request per call, seen at exactly one rising link edge
    task automatic send_req(input logic [1:0] st, input logic [4:0] cls);
        @(negedge system_interface_clock);
        coh_req_valid <= 1'b1;
        coh_req_state <= st;
        coh_req_class <= cls;
    endtask
    // released lines flip so a stale value cannot pass for a request
    task automatic idle();
        @(negedge system_interface_clock);
        coh_req_valid <= 1'b0;
        coh_req_state <= ~coh_req_state;
        coh_req_class <= ~coh_req_class;
    endtask
    // low only while every processor request is globally performed
    task automatic set_perf(input logic done);
        @(negedge system_interface_clock);
        global_perform_ack_n <= ~done;
    endtask
endmodule

// [crt_core_tb.sv]
// Purpose: self-checking bench of the coherency timing and barrier gate
// Assumes: the agent model drives all link pins
// Notes: expectations come from the latency tables, never from the design
`timescale 1ns/1ps
module crt_core_tb;
    import crt_pkg::*;
    logic clk, sys_rst, sync_req, sync_grant, coh_state_valid, coh_data_resp;
    logic system_interface_clock, global_perform_ack_n, coh_req_valid;
    logic [1:0] coh_req_state, rsp, bresp, rresp;
    logic [4:0] coh_req_class;
    logic [2:0] coherency_state_response_bus;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rdat;
    logic [3:0] wstrb;
    logic [1:0] st_q[$];
    int bad_count, checks, st_n, dm_n, ds_n, elapsed, n0, lat, i, k;
    realtime t_req;
    int st_typ[5] = '{10, 13, 14, 16, 17};
    int st_max[5] = '{39, 48, 59, 71, 79};
    int dt_typ[5] = '{28, 33, 38, 43, 43};
    int dt_max[5] = '{70, 88, 105, 128, 141};
    logic [4:0] cls[6] = '{5'h01, 5'h13, 5'h10, 5'h14, 5'h18, 5'h1c};

    crt_core dut (.clk(clk), .sys_rst(sys_rst), .system_interface_clock(system_interface_clock),
        .global_perform_ack_n(global_perform_ack_n), .coh_req_valid(coh_req_valid),
        .coh_req_state(coh_req_state), .coh_req_class(coh_req_class), .sync_req(sync_req),
        .sync_grant(sync_grant), .coh_state_valid(coh_state_valid),
        .coherency_state_response_bus(coherency_state_response_bus), .coh_data_resp(coh_data_resp),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp));
    crt_agent_model agent (.system_interface_clock(system_interface_clock),
        .global_perform_ack_n(global_perform_ack_n), .coh_req_valid(coh_req_valid),
        .coh_req_state(coh_req_state), .coh_req_class(coh_req_class));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge system_interface_clock)
        if (coh_req_valid) t_req = $realtime;
    always @(posedge clk)
    begin
        if (coh_state_valid === 1'b1)
        begin
            st_n++;
            st_q.push_back(coherency_state_response_bus[2:1]);
            elapsed = int'(($realtime - t_req) / 4.0);
        end
        dm_n += (coh_data_resp === 1'b1);
        ds_n += (coherency_state_response_bus[0] === 1'b1);
    end

    // codes above 4 fold onto the slowest cache divisor
    function automatic int exp_lat(int sc, int sy, logic [4:0] c, bit dat);
        int x, sx, mx;
        x = (sc > 4) ? 4 : sc;
        sx = (sy == 0) ? 1 : (sy == 1) ? 2 : 3;
        mx = c[2] ? ((x < 2) ? 1 : (x < 4) ? 2 : 3) : 0;
        if (dat)
            return c[1] ? 8 + sx : c[3] ? dt_max[x] + sx : dt_typ[x] + mx + sx;
        return c[0] ? 5 + sx : c[3] ? st_max[x] + sx : st_typ[x] + mx + sx;
    endfunction

    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic hang(string what);
        bad_count++;
        $display("ERROR %s expected done seen timeout", what);
        print_verdict();
    endtask

    task automatic axi_wr(logic [7:0] a, logic [31:0] dt);
        int n;
        @(posedge clk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= dt;
        wstrb <= 4'hf;
        bready <= 1'b1;
        for (n = 0; (awvalid || wvalid || bvalid !== 1'b1) && n < 99; n++)
        begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end
        if (n >= 99) hang("write response");
        rsp = bresp;
        bready <= 1'b0;
    endtask
    task automatic axi_rd(logic [7:0] a);
        int n;
        @(posedge clk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        for (n = 0; (arvalid || rvalid !== 1'b1) && n < 99; n++)
        begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end
        if (n >= 99) hang("read response");
        rsp = rresp;
        rdat = rdata;
        rready <= 1'b0;
    endtask
    task automatic wait_st(int n);
        int j;
        for (j = 0; st_n < n && j < 2000; j++) @(posedge clk);
        if (j >= 2000) hang("state response");
    endtask
    // busy and queue count both clear means every response went out
    task automatic wait_idle();
        int j;
        for (j = 0; j < 600; j++)
        begin
            axi_rd(STAT_OFS);
            if (rdat[4:1] === 4'h0) break;
        end
        if (j >= 600) hang("idle");
    endtask

    task automatic run_lat(int sc, int sy, logic m, logic [4:0] c);
        logic [1:0] st;
        int m0, s0;
        st = 2'($urandom);
        axi_wr(CTRL_OFS, {26'h0, m, 2'(sy), 3'(sc)});
        chk("latency ctrl resp", RESP_OKAY, rsp);
        n0 = st_n;
        m0 = dm_n;
        s0 = ds_n;
        agent.send_req(st, c);
        agent.idle();
        wait_st(n0 + 1);
        wait_idle();
        lat = exp_lat(sc, sy, c, 1'b0);
        chk("state code", st, st_q[$]);
        chk("state delay in window", 1, elapsed >= lat + 2 && elapsed <= lat + 8);
        axi_rd(LAT_OFS);
        chk("state latency", lat, rdat[7:0]);
        if (c[4]) chk("data latency", exp_lat(sc, sy, c, 1'b1), rdat[15:8]);
        chk("master data pulses", m0 + (c[4] & m), dm_n);
        chk("slave data pulses", s0 + (c[4] & !m), ds_n);
    endtask

    initial
    begin
        sys_rst = 1'b1;
        sync_req = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wstrb} = 20'h0;
        wdata = 32'h0;
        void'($urandom(13));
        repeat (5) @(posedge clk);
        chk("outputs in reset", 0, {sync_grant, coh_state_valid, coherency_state_response_bus,
            coh_data_resp, awready, wready, arready, bvalid, rvalid});
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        axi_rd(CTRL_OFS);
        chk("ctrl reset", CTRL_RST, rdat);
        axi_rd(CNT_OFS);
        chk("count reset", 0, rdat);
        lat = $urandom & 32'h3f;
        axi_wr(CTRL_OFS, 32'(lat));
        chk("ctrl write resp", RESP_OKAY, rsp);
        axi_rd(CTRL_OFS);
        chk("ctrl readback", lat, rdat);
        axi_wr(8'h10, 32'h3f);
        chk("unmapped write resp", RESP_SLVERR, rsp);
        axi_rd(8'h10);
        chk("unmapped read resp", RESP_SLVERR, rsp);
        chk("unmapped read data", 0, rdat);
        $display("test registers done");
        for (i = 0; i < 8; i++)
            for (k = 0; k < 6; k++)
                run_lat(i, $urandom_range(3, 0), 1'($urandom), cls[k]);
        $display("test latency done");
        axi_wr(CTRL_OFS, 32'h20);
        n0 = st_n;
        for (i = 0; i < 3; i++) agent.send_req(2'(i + 1), 5'h10);
        agent.idle();
        wait_st(n0 + 3);
        wait_idle();
        for (i = 0; i < 3; i++) chk("queued order", i + 1, st_q[n0 + i]);
        axi_wr(CTRL_OFS, 32'h34);
        n0 = st_n;
        for (i = 0; i < 9; i++) agent.send_req(2'(i), 5'h18);
        agent.idle();
        axi_rd(STAT_OFS);
        chk("overflow flag", 1, rdat[5]);
        wait_idle();
        chk("some dropped", 1, st_n - n0 < 9);
        axi_wr(STAT_OFS, 32'h20);
        axi_rd(STAT_OFS);
        chk("overflow cleared", 0, rdat[5]);
        axi_rd(CNT_OFS);
        chk("response count", st_n, rdat[15:0]);
        $display("test queue done");
        agent.set_perf(1'b0);
        repeat (80) @(posedge clk);
        sync_req <= 1'b1;
        repeat (40) @(posedge clk);
        chk("grant while held", 0, sync_grant);
        axi_rd(STAT_OFS);
        chk("perform ok held", 0, rdat[0]);
        agent.set_perf(1'b1);
        chk("grant before link edge", 0, sync_grant);
        for (i = 0; sync_grant !== 1'b1 && i < 80; i++) @(posedge clk);
        chk("grant after perform", 1, sync_grant);
        sync_req <= 1'b0;
        repeat (2) @(posedge clk);
        chk("grant drop", 0, sync_grant);
        $display("test barrier done");
        print_verdict();
    end
endmodule
